// ==== energy_ctrl_pkg.sv ====
// Notes on behaviour
// [R01] enable bit gates all energy power sequencing
// [R02] software disables auto crossover when forced mode
// [R03] auto wake once data count reaches threshold
// [R04] auto sleep when line energy disappears
// [R05] manual bit starts sequence, then self clears
// [R06] manual command toggles state ignoring thresholds, timers
// [R07] software may time manual toggle after interrupt
// [R08] burst of four pulses on each wake
// [R09] burst disabled: single pulse on wake
// [R10] power state bit shows powered up state
// [R11] software ignores power state while disabled
// [R12] error flag informational only, clears on read
// [R13] data flag set at threshold, clears on read
// [R14] error threshold field, default one
// [R15] data threshold field, default one
// [R16] error counter clears after two idle seconds
// [R17] data counter clears after two idle seconds
// [R18] auto disabled: hold state until manual command
package energy_ctrl_pkg;
	// ---------------------------------------------------------
	// register location and field positions
	// ---------------------------------------------------------
	localparam logic [4:0] REG_ADDR       = 5'h1d; // control register address
	localparam int         EN_BIT         = 15;    // mode enable
	localparam int         WAKE_BIT       = 14;    // auto wake enable
	localparam int         SLEEP_BIT      = 13;    // auto sleep enable
	localparam int         MAN_BIT        = 12;    // manual toggle
	localparam int         BURST_DIS_BIT  = 11;    // burst disable
	localparam int         PWR_BIT        = 10;    // power state
	localparam int         ERR_HIT_BIT    = 9;     // error threshold hit
	localparam int         DATA_HIT_BIT   = 8;     // data threshold hit
	localparam int         ERR_THR_LSB    = 4;     // error threshold low bit
	localparam int         DATA_THR_LSB   = 0;     // data threshold low bit
	// ---------------------------------------------------------
	// values after reset
	// ---------------------------------------------------------
	localparam logic       EN_RST         = 1'h0;  // mode off
	localparam logic       WAKE_RST       = 1'h1;  // auto wake on
	localparam logic       SLEEP_RST      = 1'h1;  // auto sleep on
	localparam logic       BURST_DIS_RST  = 1'h0;  // bursting on
	localparam logic [3:0] ERR_THR_RST    = 4'h1;  // error threshold
	localparam logic [3:0] DATA_THR_RST   = 4'h1;  // data threshold
	// ---------------------------------------------------------
	// pulse counts and timing
	// ---------------------------------------------------------
	localparam logic [2:0] BURST_LONG     = 3'h4;  // pulses per wake, bursting
	localparam logic [2:0] BURST_SHORT    = 3'h1;  // pulses per wake, no burst
	localparam int         CLK_PERIOD_NS  = 10;    // 100 MHz clock
	localparam int         IDLE_TIME_MS   = 2000;  // idle time before counter clear
	localparam int         IDLE_CYCLES    = int'((64'(IDLE_TIME_MS) * 64'd1000000)
		/ 64'(CLK_PERIOD_NS));                 // idle time in cycles
	localparam int         IDLE_W         = 28;    // idle counter width
	localparam int         PULSE_GAP_NS   = 1000;  // spacing of burst pulses
	localparam int         PULSE_GAP      = PULSE_GAP_NS / CLK_PERIOD_NS; // in cycles
	localparam int         GAP_W          = 8;     // gap counter width
	// ---------------------------------------------------------
	// line input lanes
	// ---------------------------------------------------------
	localparam int         LANE_DATA      = 0;     // data event lane
	localparam int         LANE_ERR       = 1;     // error event lane
	localparam int         LANE_PRESENT   = 2;     // energy present lane
	localparam int         LANES          = 3;     // lane count
endpackage

// ==== line_input_sync.sv ====
`timescale 1ns/1ps
module line_input_sync
	import energy_ctrl_pkg::*;
(
	input  wire logic             clk_i,   // device clock
	input  wire logic             srst_i,  // sync reset, high
	input  wire logic             ce_i,    // clock enable
	input  wire logic [LANES-1:0] line_i,  // raw line inputs
	output logic      [LANES-1:0] level_o, // synchronised levels
	output logic      [LANES-1:0] rise_o   // one-cycle rising edges
);
	// ---------------------------------------------------------
	// state
	// ---------------------------------------------------------
	typedef struct packed {
		logic [LANES-1:0] meta;  // first stage, read by second only
		logic [LANES-1:0] sync;  // second stage
		logic [LANES-1:0] prev;  // delayed copy for edges
		logic [LANES-1:0] rise;  // edge flags
	} sync_type;

	sync_type r_reg;  // registered state
	sync_type r_next; // next state

	// next state
	always_comb
	begin
		r_next      = r_reg;
		r_next.meta = line_i;
		r_next.sync = r_reg.meta;
		r_next.prev = r_reg.sync;
		r_next.rise = r_reg.sync & ~r_reg.prev;
	end

	// register, frozen while ce low
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			r_reg <= '0;
		else if (ce_i)
			r_reg <= r_next;
	end

	assign level_o = r_reg.prev;
	assign rise_o  = r_reg.rise;
endmodule

// ==== line_energy_detect_power_ctrl.sv ====
`timescale 1ns/1ps
module line_energy_detect_power_ctrl
	import energy_ctrl_pkg::*;
#(
	parameter int IDLE_LIMIT = IDLE_CYCLES  // idle cycles before counters clear
)(
	input  wire logic        clk_i,          // device clock
	input  wire logic        srst_i,         // sync reset, high
	input  wire logic        ce_i,           // clock enable
	input  wire logic [4:0]  reg_addr_i,     // management register address
	input  wire logic        reg_wr_i,       // write strobe
	input  wire logic        reg_rd_i,       // read strobe
	input  wire logic [15:0] reg_wdata_i,    // write data
	output logic      [15:0] reg_rdata_o,    // read data, next cycle
	input  wire logic        line_data_evt_i, // line data event, async
	input  wire logic        line_err_evt_i,  // line error event, async
	input  wire logic        line_energy_i,   // line energy present, async
	output logic             rx_power_up_o,  // receive side powered
	output logic             detect_pulse_o  // detection pulse to line
);
	// ---------------------------------------------------------
	// types and state
	// ---------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF  = 3'h1, // mode disabled, normal power
		ST_UP   = 3'h2, // powered up
		ST_DOWN = 3'h4  // powered down
	} state_type;

	typedef struct packed {
		state_type         state;      // power state
		logic              en;         // mode enable
		logic              auto_wake;  // auto wake enable
		logic              auto_sleep; // auto sleep enable
		logic              burst_dis;  // burst disable
		logic              man_req;    // manual toggle, one cycle
		logic              err_hit;    // error threshold hit
		logic              data_hit;   // data threshold hit
		logic [3:0]        err_thr;    // error threshold
		logic [3:0]        data_thr;   // data threshold
		logic [3:0]        err_cnt;    // error events
		logic [3:0]        data_cnt;   // data events
		logic [IDLE_W-1:0] idle_cnt;   // cycles without data event
		logic [2:0]        burst_left; // pulses still to send
		logic [GAP_W-1:0]  gap_cnt;    // cycles to next pulse
		logic              pulse;      // pulse output
		logic [15:0]       rdata;      // read data
		logic              pwr;        // powered output
	} ctrl_type;

	ctrl_type         r_reg;    // registered state
	ctrl_type         r_next;   // next state
	logic [LANES-1:0] level;    // synced line levels
	logic [LANES-1:0] rise;     // synced line edges
	logic             wr_hit;   // write to control register
	logic             rd_hit;   // read of control register
	logic [3:0]       data_inc; // data count after event
	logic [3:0]       err_inc;  // error count after event
	logic             data_met; // data threshold reached now
	logic             err_met;  // error threshold reached now

	// saturating increment
	function automatic logic [3:0] sat_inc(input logic [3:0] v);
		sat_inc = (v == 4'hf) ? v : v + 4'h1;
	endfunction

	// ---------------------------------------------------------
	// line inputs
	// ---------------------------------------------------------
	line_input_sync u_sync (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.ce_i    (ce_i),
		.line_i  ({line_energy_i, line_err_evt_i, line_data_evt_i}),
		.level_o (level),
		.rise_o  (rise)
	);

	assign wr_hit   = reg_wr_i && (reg_addr_i == REG_ADDR);
	assign rd_hit   = reg_rd_i && (reg_addr_i == REG_ADDR);
	assign data_inc = sat_inc(r_reg.data_cnt);
	assign err_inc  = sat_inc(r_reg.err_cnt);
	assign data_met = rise[LANE_DATA] && (data_inc >= r_reg.data_thr); // R13 R15
	assign err_met  = rise[LANE_ERR] && (err_inc >= r_reg.err_thr);    // R14

	// ---------------------------------------------------------
	// next state
	// ---------------------------------------------------------
	always_comb
	begin
		r_next         = r_reg;
		r_next.pulse   = 1'b0;
		r_next.man_req = 1'b0;
		// register write; manual bit lives one cycle only
		if (wr_hit)
		begin
			r_next.en         = reg_wdata_i[EN_BIT];
			r_next.auto_wake  = reg_wdata_i[WAKE_BIT];
			r_next.auto_sleep = reg_wdata_i[SLEEP_BIT];
			r_next.burst_dis  = reg_wdata_i[BURST_DIS_BIT];
			r_next.man_req    = reg_wdata_i[MAN_BIT]; // R05
			r_next.err_thr    = reg_wdata_i[ERR_THR_LSB +: 4];
			r_next.data_thr   = reg_wdata_i[DATA_THR_LSB +: 4];
		end
		// register read; manual bit reads as zero
		if (rd_hit)
		begin
			r_next.rdata = {r_reg.en, r_reg.auto_wake, r_reg.auto_sleep, 1'b0,
				r_reg.burst_dis, (r_reg.state == ST_UP), // R10
				r_reg.err_hit, r_reg.data_hit, r_reg.err_thr, r_reg.data_thr};
			r_next.err_hit  = 1'b0; // R12
			r_next.data_hit = 1'b0; // R13
		end
		// event counters with idle clear
		if (rise[LANE_DATA])
		begin
			r_next.data_cnt = data_inc;
			r_next.idle_cnt = '0;
		end
		else if (r_reg.idle_cnt == IDLE_W'(IDLE_LIMIT - 1))
		begin
			r_next.data_cnt = 4'h0; // R17
			r_next.err_cnt  = 4'h0; // R16
			r_next.idle_cnt = '0;
		end
		else
			r_next.idle_cnt = r_reg.idle_cnt + IDLE_W'(1);
		if (rise[LANE_ERR] && (r_reg.idle_cnt != IDLE_W'(IDLE_LIMIT - 1)))
			r_next.err_cnt = err_inc;
		// flags: a set in the read cycle wins
		if (err_met)
			r_next.err_hit = 1'b1; // R12
		if (data_met)
			r_next.data_hit = 1'b1; // R13
		// burst pulse generator
		if (r_reg.burst_left != 3'h0)
		begin
			if (r_reg.gap_cnt == '0)
			begin
				r_next.pulse      = 1'b1;
				r_next.burst_left = r_reg.burst_left - 3'h1;
				r_next.gap_cnt    = GAP_W'(PULSE_GAP - 1);
			end
			else
				r_next.gap_cnt = r_reg.gap_cnt - GAP_W'(1);
		end
		// power state machine
		case (r_reg.state)
			ST_OFF:
			begin
				if (r_reg.en) // R01
					r_next.state = ST_UP;
			end
			ST_UP:
			begin
				if (!r_reg.en)
					r_next.state = ST_OFF; // R01
				else if (r_reg.man_req)
					r_next.state = ST_DOWN; // R06
				else if (r_reg.auto_sleep && !level[LANE_PRESENT])
					r_next.state = ST_DOWN; // R04 R18
			end
			ST_DOWN:
			begin
				if (!r_reg.en)
					r_next.state = ST_OFF; // R01
				else if (r_reg.man_req || (r_reg.auto_wake && data_met)) // R03 R06 R18
				begin
					r_next.state      = ST_UP;
					r_next.burst_left = r_reg.burst_dis ? BURST_SHORT : BURST_LONG; // R08 R09
					r_next.gap_cnt    = '0;
					r_next.data_cnt   = 4'h0;
					r_next.err_cnt    = 4'h0;
				end
			end
			default:
				r_next.state = ST_OFF;
		endcase
		if (r_next.state == ST_DOWN)
			r_next.burst_left = 3'h0;
		r_next.pwr = (r_next.state != ST_DOWN);
	end

	// ---------------------------------------------------------
	// registers
	// ---------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			r_reg            <= '0;
			r_reg.state      <= ST_OFF;
			r_reg.en         <= EN_RST;
			r_reg.auto_wake  <= WAKE_RST;
			r_reg.auto_sleep <= SLEEP_RST;
			r_reg.burst_dis  <= BURST_DIS_RST;
			r_reg.err_thr    <= ERR_THR_RST;
			r_reg.data_thr   <= DATA_THR_RST;
			r_reg.pwr        <= 1'b1;
		end
		else if (ce_i)
			r_reg <= r_next;
	end

	assign reg_rdata_o    = r_reg.rdata;
	assign rx_power_up_o  = r_reg.pwr;
	assign detect_pulse_o = r_reg.pulse;

	// ---------------------------------------------------------
	// assertions
	// ---------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_wake_now;
		ce_i && r_reg.en && r_reg.state == ST_DOWN && !r_reg.man_req
			&& r_reg.auto_wake && data_met;
	endsequence
	// any wake out of the powered-down state, manual or automatic
	sequence s_burst_start;
		ce_i && r_reg.en && r_reg.state == ST_DOWN
			&& (r_reg.man_req || (r_reg.auto_wake && data_met));
	endsequence

	AST_DISABLED_OFF: assert property (ce_i && !r_reg.en |=> r_reg.state == ST_OFF) // R01
		else $error("state left off while mode disabled");
	AST_AUTO_WAKE: assert property (s_wake_now |=> r_reg.state == ST_UP && r_reg.pwr) // R03
		else $error("auto wake did not power up");
	AST_AUTO_SLEEP: assert property (ce_i && r_reg.en && r_reg.state == ST_UP
		&& r_reg.auto_sleep && !level[LANE_PRESENT] |=> r_reg.state == ST_DOWN) // R04
		else $error("auto sleep did not power down");
	AST_MANUAL_TOGGLE: assert property (ce_i && r_reg.en && r_reg.state == ST_UP
		&& r_reg.man_req |=> r_reg.state == ST_DOWN && !r_reg.man_req) // R05
		else $error("manual command did not toggle down");
	AST_BURST_FOUR: assert property ((s_burst_start and !r_reg.burst_dis)
		##1 ce_i [*2] |=> r_reg.burst_left == 3'h3) // R08
		else $error("burst did not start with four pulses");
	AST_BURST_ONE: assert property ((s_burst_start and r_reg.burst_dis)
		|=> r_reg.burst_left == 3'h1 && ce_i ##1 r_reg.pulse) // R09
		else $error("single pulse not sent");
	AST_PWR_BIT: assert property (ce_i && rd_hit |=> reg_rdata_o[PWR_BIT]
		== ($past(r_reg.state) == ST_UP)) // R10
		else $error("power state bit wrong");
	AST_ERR_NO_ACTION: assert property (ce_i && r_reg.en && r_reg.state == ST_DOWN
		&& !r_reg.man_req && !data_met && err_met |=> r_reg.state == ST_DOWN && r_reg.err_hit) // R12
		else $error("error event changed power state");
	AST_DATA_CLEAR: assert property (ce_i && rd_hit && !data_met |=> !r_reg.data_hit) // R13
		else $error("data flag not cleared on read");
	AST_IDLE_CLEAR: assert property (ce_i && !rise[LANE_DATA]
		&& r_reg.idle_cnt == IDLE_W'(IDLE_LIMIT - 1) |=> r_reg.data_cnt == 4'h0
		&& r_reg.err_cnt == 4'h0) // R16
		else $error("counters not cleared after idle time");
	AST_HOLD_DOWN: assert property (ce_i && r_reg.en && r_reg.state == ST_DOWN
		&& !r_reg.auto_wake && !r_reg.man_req |=> r_reg.state == ST_DOWN) // R18
		else $error("power state left without command");
endmodule

// ==== line_partner.sv ====
`timescale 1ns/1ps
// link partner on the twisted-pair line: makes events, counts pulses
module line_partner (
	input  wire logic clk_i,    // device clock
	input  wire logic pulse_i,  // detection pulses from device
	output logic      data_o,   // data events to device
	output logic      err_o,    // error events to device
	output logic      energy_o  // energy present level
);
	int seen; // detection pulses counted
	initial
	begin
		data_o   = 1'b0;
		err_o    = 1'b0;
		energy_o = 1'b1;
		seen     = 0;
	end
	// count each one-cycle pulse, sampled mid-cycle where it is settled
	always @(negedge clk_i)
		if (pulse_i === 1'b1)
			seen <= seen + 1;
	// one event: two cycles high, eight low, energy held present
	task send(input bit err);
		@(negedge clk_i);
		energy_o = 1'b1;
		if (err)
			err_o = 1'b1;
		else
			data_o = 1'b1;
		repeat (2) @(negedge clk_i);
		data_o = 1'b0;
		err_o  = 1'b0;
		repeat (8) @(negedge clk_i);
	endtask
	// line goes quiet: no energy
	task quiet();
		@(negedge clk_i);
		energy_o = 1'b0;
	endtask
endmodule

// ==== test_line_energy_detect_power_ctrl.sv ====
`timescale 1ns/1ps
module test_line_energy_detect_power_ctrl;
	import energy_ctrl_pkg::*;
	// ---------------------------------------------------------
	// signals
	// ---------------------------------------------------------
	logic        clk_i, srst_i, reg_wr_i, reg_rd_i; // clock, reset, strobes
	logic [4:0]  reg_addr_i;                         // register address
	logic [15:0] reg_wdata_i, reg_rdata_o;           // write, read data
	logic        d_evt, e_evt, energy;               // line from partner
	logic        rx_power_up_o, detect_pulse_o;      // device outputs
	int          n_mismatch, tests_run, cyc, n;      // counts, threshold
	bit          en, wk, sl, bd, up, eh, dh;         // model bits
	int          te, td, cd, cee, xp;                // model counts
	// ---------------------------------------------------------
	// design and partner
	// ---------------------------------------------------------
	line_energy_detect_power_ctrl #(.IDLE_LIMIT(50)) line_energy_detect_power_ctrl_i (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .line_data_evt_i(d_evt), .line_err_evt_i(e_evt),
		.line_energy_i(energy), .rx_power_up_o(rx_power_up_o),
		.detect_pulse_o(detect_pulse_o));
	line_partner line_partner_i (.clk_i(clk_i), .pulse_i(detect_pulse_o),
		.data_o(d_evt), .err_o(e_evt), .energy_o(energy));
	// ---------------------------------------------------------
	// clock and watchdog
	// ---------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// ---------------------------------------------------------
	// compare and bus tasks
	// ---------------------------------------------------------
	task cmp_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cmp_lvl(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	task cmp_cnt(input string nm, input int e, input int g);
		tests_run++;
		if (g != e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task wr(input logic [4:0] a, input logic [15:0] v);
		@(negedge clk_i);
		reg_addr_i  = a;
		reg_wdata_i = v;
		reg_wr_i    = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	// read, compare with model word; power bit ignored while disabled
	task rd_chk(input string nm);
		logic [15:0] m;
		m = en ? 16'hffff : 16'hfbff;
		@(negedge clk_i);
		reg_addr_i = REG_ADDR;
		reg_rd_i   = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		cmp_reg(nm, {en, wk, sl, 1'b0, bd, up & en, eh, dh, te[3:0], td[3:0]} & m,
			reg_rdata_o & m);
		eh = 1'b0;
		dh = 1'b0;
	endtask
	// ---------------------------------------------------------
	// behavioural model steps
	// ---------------------------------------------------------
	task wake_m();
		up  = 1'b1;
		cd  = 0;
		cee = 0;
		xp += bd ? 1 : 4;
	endtask
	task mwr(input logic [15:0] v);
		{en, wk, sl} = v[15:13];
		bd = v[11];
		te = v[7:4];
		td = v[3:0];
		if (en && v[12])
		begin
			up = !up;
			if (up)
				wake_m();
		end
		wr(REG_ADDR, v);
		repeat (3) @(negedge clk_i);
	endtask
	task ev(input int k, input bit err);
		repeat (k)
		begin
			line_partner_i.send(err);
			// counters and flags run whether or not the mode is on
			if (err)
			begin
				cee = (cee < 15) ? cee + 1 : 15;
				if (cee >= te) eh = 1'b1;
			end
			else
			begin
				cd = (cd < 15) ? cd + 1 : 15;
				if (cd >= td) dh = 1'b1;
				if (en && !up && wk && cd >= td) wake_m();
			end
		end
	endtask
	task idle();
		repeat (60) @(negedge clk_i);
		cd  = 0;
		cee = 0;
	endtask
	task quiet_m();
		line_partner_i.quiet();
		if (en && sl) up = 1'b0;
		repeat (8) @(negedge clk_i);
	endtask
	task chk(input string nm);
		cmp_lvl({nm, " power"}, en ? up : 1'b1, rx_power_up_o);
		cmp_cnt({nm, " pulses"}, xp, line_partner_i.seen);
		$display("test %s done", nm);
	endtask
	task report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ---------------------------------------------------------
	// main sequence; auto-negotiation stays on, no crossover concern
	// ---------------------------------------------------------
	initial
	begin
		{srst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {3'b100, 5'h00, 16'h0000};
		{n_mismatch, tests_run, cyc, cd, cee, xp} = '0;
		{en, wk, sl, bd, up, eh, dh, te, td} = {7'b0110100, 32'd1, 32'd1};
		void'($urandom(32'h0daf52ce));
		repeat (16) @(negedge clk_i);
		srst_i = 1'b0;
		rd_chk("reset");
		mwr(16'he011);
		repeat (500) @(negedge clk_i);
		rd_chk("enable");
		chk("enable");
		quiet_m();
		rd_chk("sleep");
		chk("sleep");
		n = 2 + ($urandom % 14);
		mwr(16'he010 | n[15:0]);
		ev(n - 1, 0);
		idle();
		ev(n - 1, 0);
		cmp_lvl("idle clear power", 1'b0, rx_power_up_o);
		ev(1, 0);
		repeat (400) @(negedge clk_i);
		chk("threshold wake");
		rd_chk("data flag");
		rd_chk("data flag cleared");
		quiet_m();
		mwr(16'he811);
		ev(1, 0);
		repeat (400) @(negedge clk_i);
		chk("single pulse");
		mwr(16'he831);
		ev(1, 0);
		ev(2, 1);
		idle();
		ev(1, 0);
		ev(2, 1);
		rd_chk("error below");
		ev(1, 1);
		rd_chk("error flag");
		rd_chk("error flag cleared");
		chk("error no action");
		mwr(16'h9011);
		rd_chk("manual down");
		ev(2, 0);
		ev(1, 1);
		chk("manual hold");
		mwr(16'h9011);
		quiet_m();
		repeat (400) @(negedge clk_i);
		chk("manual up");
		wr(5'h1c, 16'h0000);
		rd_chk("unmapped");
		mwr(16'h6011);
		quiet_m();
		ev(1, 0);
		rd_chk("disabled");
		chk("disabled");
		report_and_stop();
	end
endmodule
